// ### verilog/isbioe_pkg.sv
/*
 * shared types and constants of the sixteen-line serial i/o expander:
 * pin bundles, bus states, register selects and reset values.
 * assumes a single 100 MHz clock that oversamples the serial bus.
 */
`default_nettype none

package isbioe_pkg;

	// --------------------------------------------------------------
	// pin and register bundles
	// --------------------------------------------------------------
	typedef struct packed {
		logic [7:0] port_b;
		logic [7:0] port_a;
	} isbioe_lines_type;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_CMD,
		ST_WDATA,
		ST_RDATA
	} isbioe_state_type;

	// --------------------------------------------------------------
	// register selects carried in the command byte
	// --------------------------------------------------------------
	localparam logic [2:0] REG_IN0 = 3'h0;
	localparam logic [2:0] REG_IN1 = 3'h1;
	localparam logic [2:0] REG_OUT0 = 3'h2;
	localparam logic [2:0] REG_OUT1 = 3'h3;
	localparam logic [2:0] REG_POL0 = 3'h4;
	localparam logic [2:0] REG_POL1 = 3'h5;
	localparam logic [2:0] REG_CFG0 = 3'h6;
	localparam logic [2:0] REG_CFG1 = 3'h7;

	// reset values of one byte of each register kind
	localparam logic [7:0] OUT_RST = 8'hff;
	localparam logic [7:0] POL_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'hff;
	localparam logic [15:0] LINES_ZERO = 16'h0000;

	// --------------------------------------------------------------
	// serial bus constants
	// --------------------------------------------------------------
	localparam logic [4:0] DEV_ADDR_FIXED = 5'h1d; // upper five bits of 0x74
	localparam logic RW_READ = 1'b1;
	localparam logic [3:0] BIT_ZERO = 4'h0;
	localparam logic [3:0] BIT_ONE = 4'h1;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam int MCLK_KHZ = 100000;
	localparam int SCL_MAX_KHZ = 400;
	localparam int SCL_PERIOD_CYC = MCLK_KHZ / SCL_MAX_KHZ;

	// true for the two read-only input registers
	function automatic logic is_input_reg(input logic [2:0] sel);
		is_input_reg = (sel[2:1] == REG_IN0[2:1]);
	endfunction

endpackage

`default_nettype wire

// ### verilog/isbioe_regfile.sv
/*
 * register file of the expander: output, polarity and direction bytes
 * for both groups, plus a registered read port that also serves the
 * polarity-corrected input levels.
 * assumes writes arrive as one-cycle strobes from the serial engine.
 */
`timescale 1ns/100ps
`default_nettype none

module isbioe_regfile (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_clear,
	// write port
	input wire logic i_wr_en,
	input wire logic [2:0] i_wr_addr,
	input wire logic [7:0] i_wr_data,
	// read port
	input wire logic [2:0] i_rd_addr,
	input wire isbioe_pkg::isbioe_lines_type i_pins,
	output logic [7:0] o_rd_data,
	// register contents
	output isbioe_pkg::isbioe_lines_type o_out,
	output isbioe_pkg::isbioe_lines_type o_pol,
	output isbioe_pkg::isbioe_lines_type o_cfg
);
	import isbioe_pkg::*;

	logic [1:0][7:0] out_q, out_d, pol_q, pol_d, cfg_q, cfg_d;
	logic [7:0] rd_q, rd_d;
	logic [1:0][7:0] in_val;

	// --------------------------------------------------------------
	// write side
	// --------------------------------------------------------------
	// next values per group; input selects match nothing here
	always_comb begin
		out_d = out_q;
		pol_d = pol_q;
		cfg_d = cfg_q;
		for (int g = 0; g < 2; g++) begin
			if (i_clear) begin
				out_d[g] = OUT_RST;
				pol_d[g] = POL_RST;
				cfg_d[g] = CFG_RST;
			end else if (i_wr_en && !is_input_reg(i_wr_addr)) begin
				if (i_wr_addr == (REG_OUT0 | 3'(g))) begin
					out_d[g] = i_wr_data;
				end else if (i_wr_addr == (REG_POL0 | 3'(g))) begin
					pol_d[g] = i_wr_data;
				end else if (i_wr_addr == (REG_CFG0 | 3'(g))) begin
					cfg_d[g] = i_wr_data;
				end
			end
		end
	end

	// --------------------------------------------------------------
	// read side
	// --------------------------------------------------------------
	// inverted reading where the polarity bit is set
	generate
		for (genvar g = 0; g < 2; g++) begin : g_inval
			assign in_val[g] = i_pins[g*8 +: 8] ^ pol_q[g];
		end
	endgenerate

	// registered read keeps the serial shifter off a long mux path
	always_comb begin
		rd_d = rd_q;
		if (i_rd_addr[2:1] == REG_IN0[2:1]) begin
			rd_d = in_val[i_rd_addr[0]];
		end else if (i_rd_addr[2:1] == REG_OUT0[2:1]) begin
			rd_d = out_q[i_rd_addr[0]];
		end else if (i_rd_addr[2:1] == REG_POL0[2:1]) begin
			rd_d = pol_q[i_rd_addr[0]];
		end else begin
			rd_d = cfg_q[i_rd_addr[0]];
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			out_q <= {OUT_RST, OUT_RST};
			pol_q <= {POL_RST, POL_RST};
			cfg_q <= {CFG_RST, CFG_RST};
			rd_q <= POL_RST;
		end else begin
			out_q <= out_d;
			pol_q <= pol_d;
			cfg_q <= cfg_d;
			rd_q <= rd_d;
		end
	end

	assign o_rd_data = rd_q;
	assign o_out = out_q;
	assign o_pol = pol_q;
	assign o_cfg = cfg_q;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	dir_defaults_a: assert property (i_clear |=> o_cfg == {CFG_RST, CFG_RST})
		else $error("direction not all inputs after clear");
	dir_write_a: assert property (i_wr_en && !i_clear && i_wr_addr == REG_CFG1
		|=> o_cfg.port_b == $past(i_wr_data))
		else $error("direction write not taken");
	pol_read_a: assert property (i_rd_addr == REG_IN0
		|=> o_rd_data == $past(i_pins.port_a ^ o_pol.port_a))
		else $error("input read ignores polarity");
	out_read_a: assert property (i_rd_addr == REG_OUT1
		|=> o_rd_data == $past(o_out.port_b))
		else $error("output readback wrong");
	out_hold_a: assert property (!i_wr_en && !i_clear |=> $stable(o_out))
		else $error("output latch changed without write");
	in_wr_ign_a: assert property (i_wr_en && !i_clear
		&& is_input_reg(i_wr_addr)
		|=> $stable(o_out) && $stable(o_pol) && $stable(o_cfg))
		else $error("write to input register had effect");

endmodule

`default_nettype wire

// ### verilog/isbioe_top.sv
/*
 * sixteen-line serial i/o expander: bus target engine, input capture,
 * change alert and the pin drivers, around the register file.
 * assumes scl, sda, pins and straps are already synchronous to i_mclk
 * and that the bus clock stays at or below fast-mode rate.
 */
// Notes on behaviour
// - two eight-bit groups each of direction, input, output, polarity.
// - after reset every line is an input with drivers off.
// - master writes direction bits; each line follows its written bit.
// - polarity bit set reports the inverted level in the input register.
// - every register reads back its current contents.
// - reset pin low restores defaults and resets the bus engine.
// - alert asserts low when any pin differs from its captured value.
// - two strap pins set the low address bits; four devices per bus.
// - output lines keep driving the latched output value until rewritten.
// - bus works up to fast-mode rate; master never clocks faster.
// - address is 0x74 plus the two strap bits, up to 0x77.
// - command byte after write address; low three bits pick register.
// - writes to the two input registers are ignored.
// - last command stays selected for reads until a new command.
`timescale 1ns/100ps
`default_nettype none

module isbioe_top (
	// clock and resets
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_reset_n,
	// address straps
	input wire logic i_addr_select_lo,
	input wire logic i_addr_select_hi,
	// serial bus, open drain
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n,
	// i/o lines
	input wire isbioe_pkg::isbioe_lines_type i_port_lines,
	output isbioe_pkg::isbioe_lines_type o_port_lines,
	output isbioe_pkg::isbioe_lines_type o_port_lines_oe_n,
	// change alert, open drain
	output logic o_alert,
	output logic o_alert_oe_n
);
	import isbioe_pkg::*;

	// --------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------
	logic scl_q, scl_d, sda_q, sda_d, scl_p_q, scl_p_d, sda_p_q, sda_p_d;
	isbioe_state_type state_q, state_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] shift_q, shift_d;
	logic oe_n_q, oe_n_d;
	logic ack_ph_q, ack_ph_d;
	logic rw_q, rw_d;
	logic nack_q, nack_d;
	logic [2:0] cmd_q, cmd_d;
	isbioe_lines_type cap_q, cap_d;
	logic armed_q, armed_d;
	logic alert_q, alert_d;
	logic start_ev, stop_ev, rise_ev, fall_ev, byte_end;
	logic load_rd, wr_en;
	logic [6:0] dev_addr;
	logic [7:0] rd_data;
	isbioe_lines_type out_lines, pol_lines, cfg_lines;

	// --------------------------------------------------------------
	// bus sampling and events
	// --------------------------------------------------------------
	// four edges per 400 kHz bit leave ~60 samples per phase
	always_comb begin
		scl_d = i_scl;
		sda_d = i_sda;
		scl_p_d = scl_q;
		sda_p_d = sda_q;
		if (!i_reset_n) begin
			scl_d = 1'b1;
			sda_d = 1'b1;
			scl_p_d = 1'b1;
			sda_p_d = 1'b1;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_q <= scl_d;
			sda_q <= sda_d;
			scl_p_q <= scl_p_d;
			sda_p_q <= sda_p_d;
		end
	end

	assign start_ev = scl_q && scl_p_q && sda_p_q && !sda_q;
	assign stop_ev = scl_q && scl_p_q && !sda_p_q && sda_q;
	assign rise_ev = scl_q && !scl_p_q;
	assign fall_ev = !scl_q && scl_p_q;
	assign byte_end = fall_ev && !ack_ph_q && bit_q == BITS_PER_BYTE;
	assign dev_addr = {DEV_ADDR_FIXED, i_addr_select_hi,
		i_addr_select_lo};
	assign wr_en = i_reset_n && byte_end && state_q == ST_WDATA;

	// --------------------------------------------------------------
	// bus target engine and input capture
	// --------------------------------------------------------------
	// sda only changes on scl falls, so start and stop never collide
	always_comb begin
		state_d = state_q;
		bit_d = bit_q;
		shift_d = shift_q;
		oe_n_d = oe_n_q;
		ack_ph_d = ack_ph_q;
		rw_d = rw_q;
		nack_d = nack_q;
		cmd_d = cmd_q;
		cap_d = cap_q;
		armed_d = 1'b1;
		load_rd = 1'b0;
		alert_d = armed_q && (i_port_lines != cap_q);
		if (!armed_q) begin
			cap_d = i_port_lines;
		end
		if (!i_reset_n) begin
			state_d = ST_IDLE;
			bit_d = BIT_ZERO;
			shift_d = POL_RST;
			oe_n_d = 1'b1;
			ack_ph_d = 1'b0;
			rw_d = 1'b0;
			nack_d = 1'b0;
			cmd_d = REG_IN0;
			armed_d = 1'b0;
			alert_d = 1'b0;
		end else if (start_ev) begin
			state_d = ST_ADDR;
			bit_d = BIT_ZERO;
			oe_n_d = 1'b1;
			ack_ph_d = 1'b0;
		end else if (stop_ev) begin
			state_d = ST_IDLE;
			oe_n_d = 1'b1;
			ack_ph_d = 1'b0;
		end else if (rise_ev && state_q != ST_IDLE) begin
			if (ack_ph_q) begin
				nack_d = sda_q; // master ack after a read byte
			end else begin
				shift_d = {shift_q[6:0], sda_q};
				bit_d = bit_q + BIT_ONE;
				if (state_q == ST_RDATA) begin
					shift_d = {shift_q[6:0], 1'b0};
				end
			end
		end else if (fall_ev && state_q != ST_IDLE) begin
			if (byte_end) begin
				ack_ph_d = 1'b1;
				case (state_q)
					ST_ADDR: begin
						rw_d = shift_q[0];
						oe_n_d = (shift_q[7:1] != dev_addr);
					end
					ST_CMD: begin
						cmd_d = shift_q[2:0];
						oe_n_d = 1'b0;
					end
					ST_WDATA: begin
						oe_n_d = 1'b0;
					end
					default: begin
						oe_n_d = 1'b1; // master owns the ack slot
					end
				endcase
			end else if (ack_ph_q) begin
				ack_ph_d = 1'b0;
				bit_d = BIT_ZERO;
				oe_n_d = 1'b1;
				case (state_q)
					ST_ADDR: begin
						if (oe_n_q) begin
							state_d = ST_IDLE; // not ours
						end else if (rw_q == RW_READ) begin
							state_d = ST_RDATA;
							load_rd = 1'b1;
						end else begin
							state_d = ST_CMD;
						end
					end
					ST_CMD: begin
						state_d = ST_WDATA;
					end
					ST_RDATA: begin
						if (nack_q) begin
							state_d = ST_IDLE;
						end else begin
							load_rd = 1'b1;
						end
					end
					default: begin
						state_d = state_q;
					end
				endcase
			end else if (state_q == ST_RDATA) begin
				oe_n_d = shift_q[7];
			end
		end
		// first data bit goes out; reading an input re-arms its alert
		if (load_rd) begin
			shift_d = rd_data;
			oe_n_d = rd_data[7];
			if (cmd_q == REG_IN0) begin
				cap_d.port_a = i_port_lines.port_a;
			end else if (cmd_q == REG_IN1) begin
				cap_d.port_b = i_port_lines.port_b;
			end
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= ST_IDLE;
			bit_q <= BIT_ZERO;
			shift_q <= POL_RST;
			oe_n_q <= 1'b1;
			ack_ph_q <= 1'b0;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
			cmd_q <= REG_IN0;
			cap_q <= LINES_ZERO;
			armed_q <= 1'b0;
			alert_q <= 1'b0;
		end else begin
			state_q <= state_d;
			bit_q <= bit_d;
			shift_q <= shift_d;
			oe_n_q <= oe_n_d;
			ack_ph_q <= ack_ph_d;
			rw_q <= rw_d;
			nack_q <= nack_d;
			cmd_q <= cmd_d;
			cap_q <= cap_d;
			armed_q <= armed_d;
			alert_q <= alert_d;
		end
	end

	// --------------------------------------------------------------
	// register file, two groups of each kind
	// --------------------------------------------------------------
	isbioe_regfile u_regs (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_clear(!i_reset_n),
		.i_wr_en(wr_en),
		.i_wr_addr(cmd_q),
		.i_wr_data(shift_q),
		.i_rd_addr(cmd_q),
		.i_pins(i_port_lines),
		.o_rd_data(rd_data),
		.o_out(out_lines),
		.o_pol(pol_lines),
		.o_cfg(cfg_lines)
	);

	// --------------------------------------------------------------
	// pin drivers
	// --------------------------------------------------------------
	// direction one leaves a line undriven; open drains only pull low
	assign o_port_lines = out_lines;
	assign o_port_lines_oe_n = cfg_lines;
	assign o_sda = 1'b0;
	assign o_sda_oe_n = oe_n_q;
	assign o_alert = 1'b0;
	assign o_alert_oe_n = !alert_q;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	sequence s_addr_end;
		i_reset_n && byte_end && state_q == ST_ADDR;
	endsequence

	sequence s_cmd_end;
		i_reset_n && byte_end && state_q == ST_CMD;
	endsequence

	addr_hit_a: assert property (s_addr_end ##0 (shift_q[7:1] == dev_addr)
		|=> !o_sda_oe_n && ack_ph_q)
		else $error("own address not acknowledged");
	addr_miss_a: assert property (s_addr_end ##0 (shift_q[7:1] != dev_addr)
		|=> o_sda_oe_n ##1 (fall_ev || o_sda_oe_n))
		else $error("foreign address acknowledged");
	pin_reset_a: assert property (!i_reset_n |=> state_q == ST_IDLE
		&& o_sda_oe_n && o_alert_oe_n)
		else $error("reset pin did not reset bus engine");
	alert_set_a: assert property (i_reset_n && armed_q
		&& i_port_lines != cap_q |=> !o_alert_oe_n)
		else $error("alert missing on changed pin");
	alert_clr_a: assert property (i_reset_n && armed_q
		&& i_port_lines == cap_q |=> o_alert_oe_n)
		else $error("alert held with pins matching capture");
	cmd_take_a: assert property (s_cmd_end
		|=> cmd_q == $past(shift_q[2:0]))
		else $error("command byte not stored");
	cmd_hold_a: assert property (i_reset_n && !(byte_end && state_q == ST_CMD)
		|=> $stable(cmd_q))
		else $error("register select changed without command");
	dir_pin_a: assert property (o_port_lines_oe_n.port_a[0] == 1'b0
		|-> o_port_lines.port_a[0] == out_lines.port_a[0]
		&& cfg_lines.port_a[0] == 1'b0)
		else $error("line driven while set as input");

endmodule

`default_nettype wire

// ### sim/isbioe_master.sv
/*
 * bus master model for the expander bench: start, stop, bit, byte and
 * register transfer cycles on an open-drain two-wire bus.
 * assumes the bench resolves sda from both parties with a pull-up.
 */
`timescale 1ns/100ps
`default_nettype none

module isbioe_master (
	// clock
	input wire logic i_mclk,
	// resolved bus data
	input wire logic i_sda,
	// bus drive, 1 releases the line
	output logic o_scl,
	output logic o_sda
);
	// --------------------------------------------------------------
	// bit timing
	// --------------------------------------------------------------
	// quarter period; 63 or more keeps scl at fast-mode rate
	int q = 63;

	// bus idles released
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	// changes land just after an edge, never on it
	task automatic step();
		repeat (q) @(posedge i_mclk);
		#1;
	endtask

	// also serves as repeated start
	task automatic start_cond();
		o_sda = 1'b1;
		step();
		o_scl = 1'b1;
		step();
		o_sda = 1'b0;
		step();
		o_scl = 1'b0;
		step();
	endtask

	task automatic stop_cond();
		o_sda = 1'b0;
		step();
		o_scl = 1'b1;
		step();
		o_sda = 1'b1;
		step();
	endtask

	// data held over the whole high phase, sampled in its middle
	task automatic bit_io(input logic b, output logic r);
		o_sda = b;
		step();
		o_scl = 1'b1;
		step();
		r = i_sda;
		step();
		o_scl = 1'b0;
		step();
	endtask

	// --------------------------------------------------------------
	// byte and register cycles
	// --------------------------------------------------------------
	// msb first, then the target's acknowledge
	task automatic send_byte(input logic [7:0] b, output logic nak);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
		end
		bit_io(1'b1, nak);
	endtask

	// last byte gets a nack so the target lets go of sda
	task automatic recv_byte(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			b[i] = r;
		end
		bit_io(last, r);
	endtask

	// address, command byte, then one data byte
	task automatic write_reg(input logic [6:0] dev, input logic [2:0] cmd,
		input logic [7:0] d, output logic [2:0] naks);
		start_cond();
		send_byte({dev, 1'b0}, naks[0]);
		send_byte({5'h00, cmd}, naks[1]);
		send_byte(d, naks[2]); // data byte for the selected register reaches the target here
		stop_cond();
	endtask

	// command byte, repeated start, then one or two data bytes
	task automatic read_reg(input logic [6:0] dev, input logic [2:0] cmd,
		input logic two, output logic [15:0] data, output logic [2:0] naks);
		data = 16'h0000;
		start_cond();
		send_byte({dev, 1'b0}, naks[0]);
		send_byte({5'h00, cmd}, naks[1]);
		start_cond();
		send_byte({dev, 1'b1}, naks[2]);
		recv_byte(~two, data[7:0]);
		if (two) begin
			recv_byte(1'b1, data[15:8]);
		end
		stop_cond();
	endtask
endmodule

`default_nettype wire

// ### sim/isbioe_top_test.sv
/*
 * self-checking bench of the expander: a master model drives the bus,
 * an integer model predicts ports, reads and the change alert.
 * assumes the design answers within the bus timing of the master.
 */
`timescale 1ns/100ps
`default_nettype none

module isbioe_top_test;
	import isbioe_pkg::*;
	logic i_mclk, i_rst, i_reset_n, strap_lo, strap_hi;
	logic m_scl, m_sda, sda_oe_n, sda_drv, alert, alert_oe_n;
	logic [15:0] ext_pins;
	logic [31:0] rnd = 32'heb76;
	logic [6:0] dev;
	wire logic sda_w;
	isbioe_lines_type port_in, port_out, port_oe_n;
	int err_total = 0;
	int comparisons = 0;
	int cycles = 0;
	int out_m, pol_m, cfg_m, cap_m;

	// --------------------------------------------------------------
	// wires, clock, instances
	// --------------------------------------------------------------
	// pulled-up sda; lines follow our drive only where set as inputs
	assign sda_w = m_sda & (sda_oe_n | sda_drv);
	assign port_in = (~port_oe_n & port_out) | (port_oe_n & ext_pins);

	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end

	isbioe_master isbioe_master_inst (.i_mclk(i_mclk), .i_sda(sda_w),
		.o_scl(m_scl), .o_sda(m_sda));

	isbioe_top isbioe_top_inst (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_reset_n(i_reset_n), .i_addr_select_lo(strap_lo),
		.i_addr_select_hi(strap_hi), .i_scl(m_scl), .i_sda(sda_w),
		.o_sda(sda_drv), .o_sda_oe_n(sda_oe_n), .i_port_lines(port_in),
		.o_port_lines(port_out), .o_port_lines_oe_n(port_oe_n),
		.o_alert(alert), .o_alert_oe_n(alert_oe_n));

	// a hung handshake ends the run as a failure; a clean run needs
	// about 98600 cycles, so the ceiling leaves a small margin
	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (cycles == 99500) begin
			err_total++;
			report_and_stop();
		end
	end

	// --------------------------------------------------------------
	// model and helpers
	// --------------------------------------------------------------
	function automatic int rand16();
		rnd = rnd ^ (rnd << 13);
		rnd = rnd ^ (rnd >> 17);
		rnd = rnd ^ (rnd << 5);
		return int'(rnd[15:0]);
	endfunction

	// level each line shows: output latch or our external drive
	function automatic int res_m();
		return ((~cfg_m & out_m) | (cfg_m & int'(ext_pins))) & 32'hffff;
	endfunction

	function automatic int alert_m();
		return (res_m() != cap_m) ? 0 : 1;
	endfunction

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
		input string what);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h want %h", $time, what,
				seen, exp);
		end
	endtask

	task automatic settle();
		repeat (3) @(posedge i_mclk);
		#1;
	endtask

	task automatic wr(input int c, input int d);
		logic [2:0] n;
		int sh;
		int m;
		isbioe_master_inst.write_reg(dev, c[2:0], d[7:0], n);
		chk(n, 16'h0000, "write ack");
		sh = 8 * (c % 2);
		m = ~(32'hff << sh);
		// only the low byte goes over the bus
		case (c / 2)
			1: out_m = (out_m & m) | ((d & 32'hff) << sh);
			2: pol_m = (pol_m & m) | ((d & 32'hff) << sh);
			3: cfg_m = (cfg_m & m) | ((d & 32'hff) << sh);
			default: ; // input registers keep pin levels only
		endcase
	endtask

	task automatic rd(input int c, input logic two, input int e);
		logic [15:0] got;
		logic [2:0] n;
		isbioe_master_inst.read_reg(dev, c[2:0], two, got, n);
		chk(n, 16'h0000, "read ack");
		chk(got[7:0], e[7:0], "read");
		if (two) chk(got[15:8], e[7:0], "repeat");
		chk(sda_oe_n, 16'h0001, "sda release");
	endtask

	// read one input group; the read recaptures that group
	task automatic rd_in(input int g);
		rd(g, 1'b0, ((res_m() ^ pol_m) >> (8 * g)) & 32'hff);
		cap_m = (cap_m & ~(32'hff << (8 * g))) |
			(res_m() & (32'hff << (8 * g)));
	endtask

	task automatic probe(input logic [7:0] a);
		logic n;
		isbioe_master_inst.start_cond();
		isbioe_master_inst.send_byte(a, n);
		isbioe_master_inst.stop_cond();
		chk(n, 16'h0001, "foreign address");
	endtask

	task automatic check_ports(input string what);
		chk(port_out, out_m, what);
		chk(port_oe_n, cfg_m, what);
	endtask

	task automatic report_and_stop();
		if (err_total == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		i_rst = 1'b1;
		i_reset_n = 1'b1;
		{strap_hi, strap_lo} = 2'h0;
		dev = 7'h74;
		ext_pins = 16'(rand16());
		out_m = 32'hffff;
		pol_m = 32'h0;
		cfg_m = 32'hffff;
		repeat (6) @(posedge i_mclk);
		#1 i_rst = 1'b0;
		settle();
		cap_m = res_m();
		check_ports("after reset");
		chk(alert_oe_n, 16'h0001, "alert idle");
		// command codes 1 to 7, straps stepping through all four addresses
		for (int c = 1; c < 8; c++) begin
			{strap_hi, strap_lo} = c[1:0];
			dev = 7'h74 + 7'(c % 4);
			wr(c, (c == 6) ? (rand16() | 1) : rand16());
			check_ports("after write");
		end
		chk(alert_oe_n, 16'(alert_m()), "alert after writes");
		rd(7, 1'b1, (cfg_m >> 8) & 32'hff);
		// line 0 stays an input, so flipping it must raise the alert
		ext_pins = ext_pins ^ 16'h0001;
		settle();
		chk(alert_oe_n, 16'h0000, "alert on change");
		chk(alert, 16'h0000, "alert pull level");
		rd_in(0);
		rd_in(1);
		chk(alert_oe_n, 16'h0001, "alert after read");
		ext_pins = ext_pins ^ 16'h0001;
		settle();
		chk(alert_oe_n, 16'h0000, "alert again");
		ext_pins = ext_pins ^ 16'h0001;
		settle();
		chk(alert_oe_n, 16'h0001, "alert on return");
		// foreign addresses stay unanswered
		{strap_hi, strap_lo} = 2'h0;
		dev = 7'h74;
		probe({7'h75, 1'b0});
		probe(8'h00);
		// reset pin brings back defaults; master now runs slower
		i_reset_n = 1'b0;
		repeat (2) @(posedge i_mclk);
		#1 i_reset_n = 1'b1;
		settle();
		out_m = 32'hffff;
		pol_m = 32'h0;
		cfg_m = 32'hffff;
		cap_m = res_m();
		check_ports("after reset pin");
		chk(alert_oe_n, 16'h0001, "alert after reset pin");
		isbioe_master_inst.q = 70;
		rd(5, 1'b0, 32'h0);
		report_and_stop();
	end
endmodule

`default_nettype wire
